// ---- digipot_pkg.sv ----
// shared constants and types for the digital potentiometer command logic
package digipot_pkg;
  // serial command word fields
  localparam int CMD_FIELD_LSB      = 0;
  localparam int SHDN_BIT_POS       = 0;
  localparam int BIT_COUNT_BYTE     = 8;
  // command codes
  localparam logic [2:0] CMD_NOP      = 3'h0;
  localparam logic [2:0] CMD_STORE    = 3'h1;
  localparam logic [2:0] CMD_LOAD     = 3'h2;
  localparam logic [2:0] CMD_SHUTDOWN = 3'h3;
  localparam logic [2:0] CMD_RESET    = 3'h4;
  localparam logic [2:0] CMD_RD_WIPER = 3'h5;
  localparam logic [2:0] CMD_RD_NVM   = 3'h6;
  // nonvolatile read select codes
  localparam logic [1:0] NVM_SEL_WIPER = 2'h0;
  localparam logic [1:0] NVM_SEL_TOL   = 2'h1;
  // special wiper codes and reset values
  localparam logic [7:0] CODE_BOTTOM    = 8'hff;
  localparam logic [7:0] NVM_MIDSCALE   = 8'h40;
  localparam logic [7:0] WIPER_RESET    = 8'h00;
  localparam logic [7:0] READ_HI_BYTE   = 8'h00;
  localparam logic [7:0] READ_EMPTY     = 8'h00;
  // timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int RELOAD_TIME_NS = 25000;
  localparam logic [19:0] RELOAD_CYCLES = 20'(RELOAD_TIME_NS / CLK_PERIOD_NS);
  // serial engine states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_ADDR    = 8'h02,
    ST_ADDRACK = 8'h04,
    ST_WR      = 8'h08,
    ST_WRACK   = 8'h10,
    ST_RD      = 8'h20,
    ST_RDACK   = 8'h40,
    ST_IGNORE  = 8'h80
  } serial_state_t;
endpackage : digipot_pkg

// ---- digipot_wiper_command_logic.sv ----
// two-wire slave and command decoder for the nonvolatile wiper register
// Operation
// - one readback per read command only
// - command 4 reloads wiper after 25 us
// - stored wiper value ships at 0x40, midscale for 128 taps
// - command 3, bit set: shutdown on
// - command 3, bit clear: shutdown off
// - wiper decodes to 32/64/128 taps
// - code 0xff selects bottom scale
// - code equal to step count: top scale
// - rising code moves tap toward A
// - read-only tolerance byte via select 01
// - tolerance byte is sign-magnitude fixed point
// - power-on preset copies stored value to wiper
// - 16-bit word, MSB first, 3 command bits
// - decode command codes 0 through 6
// - no address acknowledge during nvm write
// - master nack withholds second read byte
`timescale 1ns/1ps
module digipot_wiper_command_logic #(
  parameter logic [6:0]  DEV_ADDR         = 7'h2f,
  parameter int          STEP_BITS        = 7,
  parameter logic [7:0]  TOLERANCE_BYTE   = 8'h00,   // arbitrary factory value, sign-magnitude
  parameter logic [19:0] NVM_WRITE_CYCLES = 20'd500000
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // two-wire bus
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // wiper state
  output logic [7:0]      wiperCode,
  output logic [6:0]      tapIndex,
  output logic            topScale,
  output logic            bottomScale,
  output logic            terminalAOpen,
  output logic            wiperToB,
  output logic            nvmBusy
);
  import digipot_pkg::*;

  localparam logic [7:0] STEPS = 8'(1 << STEP_BITS);
  localparam logic [7:0] TAP_MASK = 8'(STEPS - 8'h01);

  typedef struct packed {
    digipot_pkg::serial_state_t state;
    logic        sclS1;
    logic        sclS2;
    logic        sclPrev;
    logic        sdaS1;
    logic        sdaS2;
    logic        sdaPrev;
    logic [3:0]  bitCnt;
    logic [7:0]  shiftReg;
    logic        rwBit;
    logic        byteIdx;
    logic        ackOk;
    logic [7:0]  cmdHi;
    logic        sdaDrive;
    logic [7:0]  wiper;
    logic [7:0]  nvmWiper;
    logic        shutdown;
    logic        readArmed;
    logic [7:0]  readData;
    logic [19:0] busyCnt;
    logic        reloadKind;
    logic        presetPending;
    logic [6:0]  tap;
    logic        top;
    logic        bot;
  } core_t;

  core_t q;
  core_t d;
  logic  sclRise;
  logic  sclFall;
  logic  startCond;
  logic  stopCond;
  logic  busy;
  logic  cmdExec;
  logic [2:0] cmdCode;
  logic [7:0] cmdData;

  // bus events from synchronised samples
  assign sclRise   = q.sclS2 & ~q.sclPrev;
  assign sclFall   = ~q.sclS2 & q.sclPrev;
  assign startCond = q.sclS2 & q.sclPrev & q.sdaPrev & ~q.sdaS2;
  assign stopCond  = q.sclS2 & q.sclPrev & ~q.sdaPrev & q.sdaS2;
  assign busy      = (q.busyCnt != 20'h0);
  assign cmdCode   = q.cmdHi[2:0];          // top five bits ignored
  assign cmdData   = q.shiftReg;

  // next-state logic
  always_comb begin
    d = q;
    cmdExec = 1'b0;
    d.sclS1 = sclIn;
    d.sclS2 = q.sclS1;
    d.sclPrev = q.sclS2;
    d.sdaS1 = sdaIn;
    d.sdaS2 = q.sdaS1;
    d.sdaPrev = q.sdaS2;
    // internal cycle timer, reload lands at the end
    if (busy) begin
      d.busyCnt = q.busyCnt - 20'h1;
      if (q.busyCnt == 20'h1 && q.reloadKind) begin
        d.wiper = q.nvmWiper;
      end
    end
    // power-on preset from stored value
    if (q.presetPending) begin
      d.wiper = q.nvmWiper;
      d.presetPending = 1'b0;
    end
    case (q.state)
      ST_ADDR: begin
        if (sclRise) begin
          d.shiftReg = {q.shiftReg[6:0], q.sdaS2};
          d.bitCnt = q.bitCnt + 4'h1;
        end else if (sclFall && q.bitCnt == 4'(BIT_COUNT_BYTE)) begin
          d.rwBit = q.shiftReg[0];
          if (q.shiftReg[7:1] == DEV_ADDR && !busy) begin
            d.state = ST_ADDRACK;
            d.sdaDrive = 1'b1;
          end else begin
            d.state = ST_IGNORE;
          end
        end
      end
      ST_ADDRACK: begin
        if (sclFall) begin
          d.bitCnt = 4'h0;
          d.byteIdx = 1'b0;
          if (q.rwBit) begin
            d.readArmed = 1'b0;
            if (!q.readArmed) begin
              d.readData = READ_EMPTY;
            end
            d.shiftReg = READ_HI_BYTE;
            d.sdaDrive = ~READ_HI_BYTE[7];
            d.state = ST_RD;
          end else begin
            d.sdaDrive = 1'b0;
            d.state = ST_WR;
          end
        end
      end
      ST_WR: begin
        if (sclRise) begin
          d.shiftReg = {q.shiftReg[6:0], q.sdaS2};   // msb first
          d.bitCnt = q.bitCnt + 4'h1;
        end else if (sclFall && q.bitCnt == 4'(BIT_COUNT_BYTE)) begin
          d.sdaDrive = 1'b1;
          d.state = ST_WRACK;
          if (!q.byteIdx) begin
            d.cmdHi = q.shiftReg;
          end else begin
            cmdExec = 1'b1;
          end
        end
      end
      ST_WRACK: begin
        if (sclFall) begin
          d.sdaDrive = 1'b0;
          d.bitCnt = 4'h0;
          d.byteIdx = ~q.byteIdx;             // repeated writes pair again
          d.state = ST_WR;
        end
      end
      ST_RD: begin
        if (sclFall) begin
          if (q.bitCnt == 4'h7) begin
            d.sdaDrive = 1'b0;
            d.state = ST_RDACK;
          end else begin
            d.shiftReg = {q.shiftReg[6:0], 1'b0};
            d.sdaDrive = ~q.shiftReg[6];
            d.bitCnt = q.bitCnt + 4'h1;
          end
        end
      end
      ST_RDACK: begin
        if (sclRise) begin
          d.ackOk = ~q.sdaS2;
          if (q.sdaS2) begin
            d.state = ST_IGNORE;
          end
        end else if (sclFall) begin
          if (q.ackOk && !q.byteIdx) begin
            d.byteIdx = 1'b1;
            d.bitCnt = 4'h0;
            d.shiftReg = q.readData;
            d.sdaDrive = ~q.readData[7];
            d.state = ST_RD;
          end else begin
            d.state = ST_IGNORE;
          end
        end
      end
      default: begin
        d.sdaDrive = 1'b0;
      end
    endcase
    // start and stop override any phase
    if (startCond) begin
      d.state = ST_ADDR;
      d.bitCnt = 4'h0;
      d.sdaDrive = 1'b0;
    end else if (stopCond) begin
      d.state = ST_IDLE;
      d.sdaDrive = 1'b0;
    end
    // command decoder on the second data byte
    if (cmdExec && !busy) begin
      case (cmdCode)
        CMD_STORE: begin
          d.nvmWiper = q.wiper;
          d.busyCnt = NVM_WRITE_CYCLES;
          d.reloadKind = 1'b0;
        end
        CMD_LOAD: begin
          d.wiper = cmdData;
        end
        CMD_SHUTDOWN: begin
          d.shutdown = cmdData[SHDN_BIT_POS]; // wiper left alone
        end
        CMD_RESET: begin
          d.busyCnt = RELOAD_CYCLES;
          d.reloadKind = 1'b1;
        end
        CMD_RD_WIPER: begin
          d.readData = q.wiper;
          d.readArmed = 1'b1;
        end
        CMD_RD_NVM: begin
          d.readArmed = 1'b1;
          if (cmdData[1:0] == NVM_SEL_TOL) begin
            d.readData = TOLERANCE_BYTE;
          end else if (cmdData[1:0] == NVM_SEL_WIPER) begin
            d.readData = q.nvmWiper;
          end else begin
            d.readData = READ_EMPTY;
          end
        end
        default: begin
        end
      endcase
    end
    // tap decode; wiper register untouched by shutdown
    d.bot = (q.wiper == CODE_BOTTOM);
    d.top = (q.wiper != CODE_BOTTOM) && (q.wiper >= STEPS);
    d.tap = 7'(q.wiper & TAP_MASK);
  end

  // state register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.state <= ST_IDLE;
      q.sclS1 <= 1'b1;
      q.sclS2 <= 1'b1;
      q.sclPrev <= 1'b1;
      q.sdaS1 <= 1'b1;
      q.sdaS2 <= 1'b1;
      q.sdaPrev <= 1'b1;
      q.wiper <= WIPER_RESET;
      q.nvmWiper <= NVM_MIDSCALE;
      q.presetPending <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs
  assign sdaOut        = 1'b0;
  assign sdaOe         = q.sdaDrive;
  assign wiperCode     = q.wiper;
  assign tapIndex      = q.tap;
  assign topScale      = q.top;
  assign bottomScale   = q.bot;
  assign terminalAOpen = q.shutdown;
  assign wiperToB      = q.shutdown | q.bot;
  assign nvmBusy       = busy;

  // checks
  a_shdn_enter: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmdExec && !busy && cmdCode == CMD_SHUTDOWN && cmdData[0] |=> terminalAOpen && wiperToB)
    else $error("shutdown not entered");
  a_shdn_leave: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmdExec && !busy && cmdCode == CMD_SHUTDOWN && !cmdData[0] |=> !terminalAOpen)
    else $error("shutdown not released");
  a_shdn_holds_wiper: assert property (@(posedge clk_sys) disable iff (!resetn)
    q.shutdown && !cmdExec && !busy && !q.presetPending |=> wiperCode == $past(wiperCode))
    else $error("wiper changed in shutdown");
  a_reset_timer: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmdExec && !busy && cmdCode == CMD_RESET |=> q.busyCnt == RELOAD_CYCLES ##1 nvmBusy [*3])
    else $error("reload timer wrong");
  a_reload_lands: assert property (@(posedge clk_sys) disable iff (!resetn)
    q.busyCnt == 20'h1 && q.reloadKind |=> wiperCode == $past(q.nvmWiper) && !nvmBusy)
    else $error("reload not applied");
  a_bottom_code: assert property (@(posedge clk_sys) disable iff (!resetn)
    wiperCode == CODE_BOTTOM |=> bottomScale && !topScale && wiperToB)
    else $error("bottom scale missed");
  a_top_code: assert property (@(posedge clk_sys) disable iff (!resetn)
    wiperCode == STEPS |=> topScale && !bottomScale)
    else $error("top scale missed");
  a_tap_follows: assert property (@(posedge clk_sys) disable iff (!resetn)
    wiperCode < STEPS |=> tapIndex == 7'($past(wiperCode)) && !topScale)
    else $error("tap does not follow code");
  a_busy_nack: assert property (@(posedge clk_sys) disable iff (!resetn)
    q.state == ST_ADDR && sclFall && q.bitCnt == 4'h8 && busy && !startCond |=> !sdaOe [*2])
    else $error("address acked while busy");
  a_read_once: assert property (@(posedge clk_sys) disable iff (!resetn)
    q.state == ST_ADDRACK && q.rwBit && sclFall && !startCond && !stopCond |=> !q.readArmed)
    else $error("readback left armed");
  a_nack_withhold: assert property (@(posedge clk_sys) disable iff (!resetn)
    q.state == ST_RDACK && sclRise && q.sdaS2 && !startCond |=> q.state == ST_IGNORE ##1 !sdaOe)
    else $error("second byte not withheld");
  a_tol_read: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmdExec && !busy && cmdCode == CMD_RD_NVM && cmdData[1:0] == NVM_SEL_TOL
    |=> q.readData == TOLERANCE_BYTE && q.readArmed)
    else $error("tolerance byte not staged");
  a_preset: assert property (@(posedge clk_sys) disable iff (!resetn)
    q.presetPending |=> wiperCode == $past(q.nvmWiper) && !q.presetPending)
    else $error("power-on preset missed");
  c_write_cmd: cover property (@(posedge clk_sys) disable iff (!resetn) cmdExec && cmdCode == CMD_LOAD);
  c_read_two: cover property (@(posedge clk_sys) disable iff (!resetn)
    q.state == ST_RDACK && sclFall && q.ackOk && !q.byteIdx);
  c_busy_nack: cover property (@(posedge clk_sys) disable iff (!resetn)
    q.state == ST_ADDR && sclFall && q.bitCnt == 4'h8 && busy);
  c_shutdown: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(terminalAOpen));
endmodule : digipot_wiper_command_logic

// ---- digipot_bus_master.sv ----
// two-wire bus master model that drives the potentiometer slave
`timescale 1ns/1ps
module digipot_bus_master (
  // bus lines, sda released means pulled up
  output logic      sclPin,
  output logic      sdaLow,
  input  wire logic sdaWire
);
  // bus idles high, clock stands still between frames
  initial begin
    sclPin = 1'b1;
    sdaLow = 1'b0;
  end
  // one bit: data set in low phase, sampled halfway through high phase
  task automatic bitx(input logic b, output logic r);
    #10 sdaLow = ~b;
    #30 sclPin = 1'b1;
    #20 r = sdaWire;
    #20 sclPin = 1'b0;
  endtask : bitx
  // start or repeated start
  task automatic start;
    #10 sdaLow = 1'b0;
    #30 sclPin = 1'b1;
    #40 sdaLow = 1'b1;
    #40 sclPin = 1'b0;
  endtask : start
  // stop leaves the bus idle
  task automatic stop;
    #10 sdaLow = 1'b1;
    #30 sclPin = 1'b1;
    #40 sdaLow = 1'b0;
    #40;
  endtask : stop
  // one byte plus the ninth clock; last high releases sda there
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ackLow);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r); // msb first
      q[i] = r;
    end
    bitx(last, r); // master nack ends a read
    ackLow = ~r;
  endtask : xfer
endmodule : digipot_bus_master

// ---- digipot_wiper_command_logic_tb.sv ----
// self-checking bench for the wiper command logic
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module digipot_wiper_command_logic_tb;
  import digipot_pkg::*;
  localparam logic [6:0] ADDR = 7'h2f;
  localparam logic [7:0] TOL  = 8'h52; // arbitrary factory value
  typedef struct packed {
    logic [2:0]  cmd;
    logic [7:0]  data;
    logic [18:0] res;
  } row_t;
  // expected {wiperCode, tapIndex, top, bottom, aOpen, toB}
  localparam row_t ROWS [8] = '{
    '{CMD_LOAD, 8'h10, {8'h10, 7'h10, 4'h0}},
    '{CMD_LOAD, 8'h7f, {8'h7f, 7'h7f, 4'h0}},
    '{CMD_LOAD, 8'h80, {8'h80, 7'h00, 4'h8}},
    '{CMD_LOAD, 8'hff, {8'hff, 7'h7f, 4'h5}},
    '{CMD_LOAD, 8'h20, {8'h20, 7'h20, 4'h0}},
    '{CMD_SHUTDOWN, 8'h01, {8'h20, 7'h20, 4'h3}},
    '{CMD_NOP, 8'h55, {8'h20, 7'h20, 4'h3}},
    '{CMD_SHUTDOWN, 8'h00, {8'h20, 7'h20, 4'h0}}};
  logic       clk_sys;
  logic       resetn;
  logic       sclPin;
  logic       sdaLow;
  logic       sdaOut;
  logic       sdaOe;
  logic [7:0] wiperCode;
  logic [6:0] tapIndex;
  logic       topScale;
  logic       bottomScale;
  logic       terminalAOpen;
  logic       wiperToB;
  logic       nvmBusy;
  logic [7:0] q0;
  logic [7:0] q1;
  logic       a0;
  logic       a1;
  logic       a2;
  int         errors;
  int         checks_done;
  int         n;
  // open-drain wire with pull-up
  wire sdaWire = (sdaOe ? sdaOut : 1'b1) & ~sdaLow;
  // decoded outputs in row order
  wire [18:0] rowOut = {wiperCode, tapIndex, topScale, bottomScale, terminalAOpen, wiperToB};
  digipot_wiper_command_logic #(.DEV_ADDR(ADDR), .STEP_BITS(7), .TOLERANCE_BYTE(TOL),
    .NVM_WRITE_CYCLES(20'hc8)) uut (
    .clk_sys(clk_sys), .resetn(resetn), .sclIn(sclPin), .sdaIn(sdaWire), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .wiperCode(wiperCode), .tapIndex(tapIndex), .topScale(topScale),
    .bottomScale(bottomScale), .terminalAOpen(terminalAOpen), .wiperToB(wiperToB),
    .nvmBusy(nvmBusy));
  digipot_bus_master m (.sclPin(sclPin), .sdaLow(sdaLow), .sdaWire(sdaWire));
  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  // write one command word, all three bytes acked
  task automatic wcmd(input logic [2:0] c, input logic [7:0] d);
    m.start();
    m.xfer({ADDR, 1'b0}, 1'b1, q0, a0);
    m.xfer({5'h00, c}, 1'b1, q0, a1);
    m.xfer(d, 1'b1, q0, a2);
    m.stop();
    `CHK({a0, a1, a2}, 3'h7)
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : wcmd
  // read two bytes, nk set means nack on the first one
  task automatic rd(input logic nk);
    m.start();
    m.xfer({ADDR, 1'b1}, 1'b1, q0, a0);
    m.xfer(8'hff, nk, q0, a1);
    m.xfer(8'hff, 1'b1, q1, a2);
    m.stop();
    `CHK(a0, 1'b1)
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : rd
  // address poll, a0 tells whether it was acked
  task automatic poll;
    m.start();
    m.xfer({ADDR, 1'b0}, 1'b1, q0, a0);
    m.stop();
  endtask : poll
  // hang guard
  initial begin
    #500us;
    errors++;
    report_and_stop();
  end
  // main sequence
  initial begin
    resetn = 1'b0;
    errors = 0;
    checks_done = 0;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK(wiperCode, WIPER_RESET)
    resetn = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK(wiperCode, NVM_MIDSCALE)
    foreach (ROWS[i]) begin
      wcmd(ROWS[i].cmd, ROWS[i].data);
      `CHK(rowOut, ROWS[i].res)
    end
    // readback once, then no repeat
    wcmd(CMD_RD_WIPER, 8'h00);
    rd(1'b0);
    `CHK({q0, q1}, 16'h0020)
    rd(1'b0);
    `CHK(q1, 8'h00)
    wcmd(CMD_RD_NVM, {6'h00, NVM_SEL_TOL});
    rd(1'b0);
    `CHK(q1, TOL)
    // nack on first byte: second byte left to the pull-up
    wcmd(CMD_RD_WIPER, 8'h00);
    rd(1'b1);
    `CHK(q1, 8'hff)
    // store, then poll through the write cycle
    wcmd(CMD_LOAD, 8'h33);
    wcmd(CMD_STORE, 8'h00);
    `CHK(nvmBusy, 1'b1)
    poll();
    `CHK(a0, 1'b0)
    for (int k = 0; k < 10 && !a0; k++)
      poll();
    `CHK(a0, 1'b1)
    wcmd(CMD_RD_NVM, {6'h00, NVM_SEL_WIPER});
    rd(1'b0);
    `CHK(q1, 8'h33)
    // software reset reloads the stored value after the delay
    wcmd(CMD_LOAD, 8'h05);
    wcmd(CMD_RESET, 8'h00);
    n = 0;
    while (nvmBusy === 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n == 2300)
        `CHK(wiperCode, 8'h05)
    end
    `CHK(n >= 2400 && n <= 2500, 1'b1)
    repeat (3) @(posedge clk_sys);
    `CHK(wiperCode, 8'h33)
    // three pairs in one frame; the last lands while busy and is dropped
    #1;
    m.start();
    m.xfer({ADDR, 1'b0}, 1'b1, q0, a0);
    m.xfer({5'h00, CMD_LOAD}, 1'b1, q0, a1);
    m.xfer(8'h44, 1'b1, q0, a2);
    m.xfer({5'h00, CMD_STORE}, 1'b1, q0, a1);
    m.xfer(8'h00, 1'b1, q0, a2);
    m.xfer({5'h00, CMD_LOAD}, 1'b1, q0, a1);
    m.xfer(8'h11, 1'b1, q0, a2);
    m.stop();
    `CHK({a0, a1, a2}, 3'h7)
    `CHK(wiperCode, 8'h44)
    `CHK(nvmBusy, 1'b1)
    repeat (100) @(posedge clk_sys);
    #1;
    wcmd(CMD_RD_NVM, {6'h00, NVM_SEL_WIPER});
    rd(1'b0);
    `CHK(q1, 8'h44)
    // unused select code stages an empty byte
    wcmd(CMD_RD_NVM, 8'h02);
    rd(1'b0);
    `CHK(q1, READ_EMPTY)
    // reset in mid-run repeats the preset
    #1 resetn = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 resetn = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK(wiperCode, NVM_MIDSCALE)
    report_and_stop();
  end
endmodule : digipot_wiper_command_logic_tb
